/* File: pkg/sipo_pkg.sv */
package sipo_pkg;
  // chain geometry
  localparam int STAGES = 8;
  localparam int FIFO_DEPTH = 4;
  // event word layout
  localparam int EV_DATA = 0;
  localparam int EV_STB_RISE = 1;
  localparam int EV_STB_FALL = 2;
  localparam int EV_CLK_FALL = 3;
  localparam int EV_CLK_RISE = 4;
  localparam int EV_W = 5;
  // values after reset
  localparam logic [STAGES-1:0] CHAIN_RST = 8'h00;
  localparam logic [STAGES-1:0] LATCH_RST = 8'h00;
  localparam logic BIT_RST = 1'h0;
  localparam logic OE_N_RST = 1'h1;
endpackage

/* File: src/sipo_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sipo_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word in
  output logic out_valid, // word available
  input wire logic out_ready, // consumer takes word
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // occupancy and flags
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rd_ptr];

  ////////////////////////////////////////////////////////////////////////
  // pointers, count and registered full/empty
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'h1;
      out_valid <= 1'h0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'h1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'h1;
      end
      count <= next_count;
      in_ready <= (next_count != DEPTH_C);
      out_valid <= (next_count != '0);
    end
  end

  // storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire

/* File: src/sipo_shift_store.sv */
// Contract
// (RQ1) Each shift-clock rise moves the eight-stage chain one place, serial data entering stage one; a rise that finds the event queue full is dropped.
// (RQ2) Each shift-clock rise copies stage seven into stage eight and the fast cascade output; a rise that finds the event queue full is dropped.
// (RQ3) The slow cascade output takes stage seven on the following shift-clock fall and holds at rises.
// (RQ4) A strobe fall makes every storage latch capture and hold its chain stage.
// (RQ5) With strobe high the latches follow the chain; with strobe low they hold.
// (RQ6) Output enable low floats all parallel outputs; high drives the latch contents.
// (RQ7) Two serial cascade outputs leave the chain end, one on each clock edge.
// (RQ8) Both cascade outputs keep updating whatever the output enable level.
`timescale 1ns/1ps
`default_nettype none
module sipo_shift_store
  import sipo_pkg::*;
#(
  parameter int NSTAGE = sipo_pkg::STAGES,
  parameter int DEPTH = sipo_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk, // 25 MHz system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic shift_clk_pin, // shift clock from controller
  input wire logic serial_data_pin, // serial data in
  input wire logic strobe_pin, // latch strobe
  input wire logic out_enable_pin, // parallel output enable
  input wire logic drain_hold, // stalls event processing
  output logic [NSTAGE-1:0] parallel_out, // latch contents
  output logic parallel_oe_n, // low while outputs driven
  output logic final_stage_out, // fast cascade, rising edge
  output logic slow_cascade_out, // slow cascade, falling edge
  output logic event_ready // event queue has room
);
  import sipo_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops each, stage two only is read
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic clk_prev;
  logic stb_prev;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {out_enable_pin, strobe_pin, serial_data_pin, shift_clk_pin};
      sync_b <= sync_a;
    end
  end

  wire clk_s = sync_b[0];
  wire data_s = sync_b[1];
  wire stb_s = sync_b[2];
  wire oe_s = sync_b[3];

  // shift clock history, one cycle behind the synchronised level
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      clk_prev <= BIT_RST;
    end else begin
      clk_prev <= clk_s;
    end
  end

  // strobe history; reset low so a strobe held high opens the latches
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stb_prev <= BIT_RST;
    end else begin
      stb_prev <= stb_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge decode into one event word per cycle
  wire clk_rise = clk_s && !clk_prev;
  wire clk_fall = !clk_s && clk_prev;
  wire stb_rise = stb_s && !stb_prev;
  wire stb_fall = !stb_s && stb_prev;
  wire any_event = clk_rise || clk_fall || stb_rise || stb_fall;
  wire [EV_W-1:0] ev_in = {clk_rise, clk_fall, stb_fall, stb_rise, data_s};

  ////////////////////////////////////////////////////////////////////////
  // event queue keeps edge order while the chain is stalled
  logic fifo_in_ready;
  logic ev_valid;
  logic [EV_W-1:0] ev;
  // the chain consumes one event per cycle unless stalled
  wire pop_ok = !drain_hold;
  wire take = ev_valid && pop_ok;

  sipo_fifo #(
    .WIDTH(EV_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(any_event),
    .in_ready(fifo_in_ready),
    .in_data(ev_in),
    .out_valid(ev_valid),
    .out_ready(pop_ok),
    .out_data(ev)
  );

  ////////////////////////////////////////////////////////////////////////
  // chain state: stages one to seven, stage eight is final_stage_out
  logic [NSTAGE-2:0] chain;
  logic stb_level;
  wire seventh_stage_value = chain[NSTAGE-2];
  // named fields of the event at the queue head
  wire ev_data = ev[EV_DATA];
  wire ev_clk_rise = ev[EV_CLK_RISE];
  wire ev_clk_fall = ev[EV_CLK_FALL];
  wire ev_stb_rise = ev[EV_STB_RISE];
  wire ev_stb_fall = ev[EV_STB_FALL];
  wire do_shift = take && ev_clk_rise;
  wire do_fall = take && ev_clk_fall;
  wire stb_set = take && ev_stb_rise;
  wire stb_clr = take && ev_stb_fall;
  logic [NSTAGE-2:0] next_chain;
  logic [NSTAGE-1:0] next_latch;
  genvar gi;

  // chain stages: stage one takes serial data, the rest the stage before
  generate
    for (gi = 0; gi < NSTAGE - 1; gi++) begin : g_chain
      if (gi == 0) begin : g_first
        assign next_chain[gi] = do_shift ? ev_data : chain[gi]; // RQ1
      end else begin : g_rest
        assign next_chain[gi] = do_shift ? chain[gi-1] : chain[gi]; // RQ1
      end
    end
  endgenerate

  // stage eight moves only on a shift
  wire next_final = do_shift ? seventh_stage_value : final_stage_out; // RQ2
  wire [NSTAGE-1:0] next_stages = {next_final, next_chain};
  // strobe level as seen by the queued events
  wire next_stb = stb_set ? 1'h1 : (stb_clr ? 1'h0 : stb_level);
  // latches open while strobe high, and capture on the fall itself
  wire latch_open = next_stb || stb_clr; // RQ5

  // per stage: an open latch follows its stage, a closed one holds
  generate
    for (gi = 0; gi < NSTAGE; gi++) begin : g_latch
      assign next_latch[gi] = latch_open ? next_stages[gi] :
        parallel_out[gi]; // RQ4 RQ5
    end
  endgenerate

  // slow cascade: stage seven on the falling edge only, held at rises
  wire next_slow = do_fall ? seventh_stage_value : slow_cascade_out; // RQ3

  ////////////////////////////////////////////////////////////////////////

  // shift chain and fast cascade, never gated by output enable
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      chain <= CHAIN_RST[NSTAGE-2:0];
      final_stage_out <= BIT_RST;
    end else begin
      chain <= next_chain; // RQ1
      final_stage_out <= next_final; // RQ2 RQ7 RQ8
    end
  end

  // slow cascade register, never gated by output enable
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      slow_cascade_out <= BIT_RST;
    end else begin
      slow_cascade_out <= next_slow; // RQ3 RQ7 RQ8
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strobe level tracker
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stb_level <= BIT_RST;
    end else begin
      stb_level <= next_stb; // RQ5
    end
  end

  // storage latches
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      parallel_out <= LATCH_RST[NSTAGE-1:0];
    end else begin
      parallel_out <= next_latch; // RQ4 RQ5
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // three-state control, high floats the parallel outputs
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      parallel_oe_n <= OE_N_RST;
    end else begin
      parallel_oe_n <= !oe_s; // RQ6
    end
  end

  // queue status, one cycle behind the queue's own flag
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      event_ready <= 1'h1;
    end else begin
      event_ready <= fifo_in_ready;
    end
  end
endmodule
`default_nettype wire

/* File: test/sipo_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module sipo_ctrl (
  input wire logic sys_clk, // clock
  output logic sclk, // shift clock
  output logic sdat, // data
  output logic stb, // strobe
  output logic oe // enable
);
  // idle: clock low, latch open, outputs on
  initial begin
    sclk = 0;
    sdat = 0;
    stb = 1;
    oe = 1;
  end
  // one pin state, held six cycles
  task automatic put(input logic c, d, s, o);
    @(posedge sys_clk);
    sclk <= c;
    sdat <= d;
    stb <= s;
    oe <= o;
    repeat (5) @(posedge sys_clk);
  endtask
  // msb first, data set up before each rise
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      put(0, b[i], stb, oe);
      put(1, b[i], stb, oe);
    end
    put(0, 0, stb, oe);
  endtask
endmodule
`default_nettype wire

/* File: test/sipo_shift_store_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sipo_shift_store_chk #(
  parameter int NSTAGE = 8
) (
  input wire logic sys_clk, // clock
  input wire logic rstn, // reset
  input wire logic shift_clk_pin, // shift clock
  input wire logic strobe_pin, // strobe
  input wire logic out_enable_pin, // enable
  input wire logic drain_hold, // stall
  input wire logic [NSTAGE-1:0] parallel_out, // latches
  input wire logic parallel_oe_n, // float
  input wire logic final_stage_out, // fast
  input wire logic slow_cascade_out, // slow
  input wire logic event_ready // room
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // settled steady-state relations
  property p_off; $fell(out_enable_pin) |-> ##[1:5] parallel_oe_n; endproperty
  a_off: assert property (p_off) else $error("no float");
  property p_on; $rose(out_enable_pin) |-> ##[1:5] !parallel_oe_n; endproperty
  a_on: assert property (p_on) else $error("no drive");
  property p_fh; (!shift_clk_pin && !drain_hold)[*8] |-> $stable(final_stage_out);
  endproperty
  a_fh: assert property (p_fh) else $error("fast moved");
  property p_sh; (shift_clk_pin && !drain_hold)[*5] |-> $stable(slow_cascade_out);
  endproperty
  a_sh: assert property (p_sh) else $error("slow moved");
  property p_lh; (!strobe_pin && !drain_hold)[*8] |-> $stable(parallel_out);
  endproperty
  a_lh: assert property (p_lh) else $error("latch moved");
  property p_tr; (strobe_pin && !drain_hold)[*8] |->
    parallel_out[NSTAGE-1] == final_stage_out; endproperty
  a_tr: assert property (p_tr) else $error("fast vs stage");
  property p_s7; (strobe_pin && !shift_clk_pin && !drain_hold)[*5] |->
    slow_cascade_out == parallel_out[NSTAGE-2]; endproperty
  a_s7: assert property (p_s7) else $error("slow vs stage");
  property p_sf; $rose(shift_clk_pin) && strobe_pin && !drain_hold |->
    ##[2:6] parallel_out[NSTAGE-1:1] == $past(parallel_out[NSTAGE-2:0]);
  endproperty
  a_sf: assert property (p_sf) else $error("no shift");
  c_full: cover property (!event_ready);
  c_cap: cover property ($fell(strobe_pin));
  c_off: cover property (!out_enable_pin && $rose(shift_clk_pin));
endmodule
bind sipo_shift_store sipo_shift_store_chk #(.NSTAGE(NSTAGE)) i_chk (
  .sys_clk, .rstn, .shift_clk_pin, .strobe_pin, .out_enable_pin,
  .drain_hold, .parallel_out, .parallel_oe_n, .final_stage_out,
  .slow_cascade_out, .event_ready);
`default_nettype wire

/* File: test/tb_sipo_shift_store.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sipo_shift_store;
  import sipo_pkg::*;
  logic sys_clk = 0;
  logic rstn = 0;
  logic drain_hold = 0;
  logic sclk, sdat, stb, oe, oe_n, fast, slow, rdy;
  logic [STAGES-1:0] pout;
  int err_total = 0;
  int compares = 0;
  sipo_ctrl i_sipo_ctrl (.sys_clk, .sclk, .sdat, .stb, .oe);
  sipo_shift_store i_sipo_shift_store (.sys_clk, .rstn, .shift_clk_pin(sclk),
    .serial_data_pin(sdat), .strobe_pin(stb), .out_enable_pin(oe),
    .drain_hold, .parallel_out(pout), .parallel_oe_n(oe_n),
    .final_stage_out(fast), .slow_cascade_out(slow), .event_ready(rdy));
  // 25 MHz clock
  initial forever #20 sys_clk = ~sys_clk;
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'h1) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_load;
    chk(pout === LATCH_RST && oe_n === OE_N_RST, "reset");
    i_sipo_ctrl.send(8'hA5);
    chk(pout === 8'hA5, "open");
    i_sipo_ctrl.put(0, 0, 0, 1);
    chk(pout === 8'hA5 && fast && !slow, "load");
    $display("load end");
  endtask
  task automatic t_hold;
    i_sipo_ctrl.send(8'h5C);
    chk(pout === 8'hA5 && fast === 1'h0 && slow === 1'h1, "hold");
    i_sipo_ctrl.put(0, 0, 1, 1);
    chk(pout === 8'h5C, "follow");
    $display("hold end");
  endtask
  task automatic t_oe;
    i_sipo_ctrl.put(0, 0, 0, 0);
    chk(oe_n === 1'h1, "float");
    i_sipo_ctrl.send(8'hC3);
    chk(fast === 1'h1 && slow === 1'h1 && pout === 8'h5C, "cascade");
    i_sipo_ctrl.put(0, 0, 0, 1);
    chk(oe_n === 1'h0, "drive");
    $display("oe end");
  endtask
  // 48 shift-clock events into a four-deep queue, then drain
  task automatic t_fill;
    @(posedge sys_clk);
    drain_hold <= 1;
    repeat (3) i_sipo_ctrl.send(8'h00);
    chk(rdy === 1'h0, "full");
    @(posedge sys_clk);
    drain_hold <= 0;
    i_sipo_ctrl.put(0, 0, 0, 1);
    chk(rdy === 1'h1, "drained");
    i_sipo_ctrl.send(8'h81);
    i_sipo_ctrl.put(0, 0, 1, 1);
    i_sipo_ctrl.put(0, 0, 0, 1);
    chk(pout === 8'h81, "refill");
    $display("fill end");
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1;
    t_load;
    t_hold;
    t_oe;
    t_fill;
    conclude;
  end
endmodule
`default_nettype wire
